// *** rtl/ebs_pkg.sv ***
// Constants, types and register map of the encoder backup supervisor.
// Assumes a single 25 MHz clock and an AXI4-Lite register master.
`default_nettype none
package ebs_pkg;
	// Register byte offsets
	localparam logic [7:0] EBS_CTRL = 8'h00;
	localparam logic [7:0] EBS_STATUS = 8'h04;
	localparam logic [7:0] EBS_IRQ_STAT = 8'h08;
	localparam logic [7:0] EBS_IRQ_MASK = 8'h0C;
	// Control bits
	localparam int EBS_CTRL_INC = 0;
	localparam int EBS_CTRL_CLR = 1;
	// Interrupt event bits
	localparam int EBS_EV_BKP = 0;
	localparam int EBS_EV_ENC = 1;
	localparam int EBS_EV_LOW = 2;
	localparam int EBS_EV_HOME = 3;
	localparam int EBS_EV_W = 4;
	// Reset values
	localparam logic EBS_INC_RST = 1'b0;
	localparam logic [3:0] EBS_MASK_RST = 4'h0;
	// Bus answers
	localparam logic [1:0] EBS_OKAY = 2'h0;
	localparam logic [1:0] EBS_SLVERR = 2'h2;
	// Displayed error, first occurrence kept
	localparam logic [1:0] EBS_DSP_NONE = 2'h0;
	localparam logic [1:0] EBS_DSP_OTHER = 2'h1;
	localparam logic [1:0] EBS_DSP_BKP = 2'h2;
	localparam logic [1:0] EBS_DSP_ENC = 2'h3;
	// Supply and speed limits, millivolts and revolutions per minute
	localparam logic [11:0] EBS_WARN_MV = 12'd2700;
	localparam logic [11:0] EBS_MIN_MV = 12'd2500;
	localparam logic [15:0] EBS_BKP_RPM_MAX = 16'd5000;
	localparam logic [15:0] EBS_PWRUP_RPM_MAX = 16'd200;
	// Indicator flash half period
	localparam int EBS_CLK_HZ = 25_000_000;
	localparam int EBS_BLINK_HALF_MS = 250;
	localparam int EBS_BLINK_CYC = EBS_CLK_HZ / 1000 * EBS_BLINK_HALF_MS;
	// Synchronised pin bundle
	localparam int EBS_PIN_W = 34;
	typedef enum logic [1:0] {EBS_ST_OFF = 2'b01, EBS_ST_ON = 2'b10} ebs_pwr_t;
endpackage
`default_nettype wire

// *** rtl/ebs_top.sv ***
// Encoder backup supervisor for one servo axis, with AXI4-Lite registers.
// Assumes pins are asynchronous and the axis has its own instance and LED.
//
// Register access over AXI4-Lite and the address map are this design's own decisions.
`default_nettype none
module ebs_top
	import ebs_pkg::*;
#(
	parameter int BLINK_CYC = ebs_pkg::EBS_BLINK_CYC
)(
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	// AXI4-Lite read
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Axis pins
	input wire logic ctrl_pwr_on,
	input wire logic cable_ok,
	input wire logic motor_new,
	input wire logic reset_in,
	input wire logic estop_in,
	input wire logic home_done,
	input wire logic [11:0] bkp_mv,
	input wire logic [15:0] speed_rpm,
	// Axis outputs
	output logic led_green,
	output logic err_out,
	output logic motion_inhibit,
	output logic abs_active,
	output logic [1:0] disp_err,
	output logic irq
);
	import ebs_pkg::*;

	localparam int CW = $clog2(BLINK_CYC + 1);

	typedef struct packed {
		ebs_pwr_t st;
		logic [EBS_PIN_W-1:0] s1;
		logic [EBS_PIN_W-1:0] s2;
		logic [3:0] p;
		logic [1:0] up;
		logic inc;
		logic f_low;
		logic f_ovs;
		logic f_cab;
		logic bkp;
		logic enc;
		logic inh;
		logic low;
		logic led;
		logic err;
		logic abs;
		logic irq;
		logic [1:0] disp;
		logic [EBS_EV_W-1:0] ist;
		logic [EBS_EV_W-1:0] imsk;
		logic [CW-1:0] cnt;
		logic aw_got;
		logic w_got;
		logic [7:0] awa;
		logic [31:0] wd;
		logic [3:0] ws;
		logic awr;
		logic wr;
		logic bv;
		logic [1:0] br;
		logic arr;
		logic rv;
		logic [31:0] rd;
		logic [1:0] rr;
	} ebs_state_t;

	localparam ebs_state_t Q_RST = '{st: EBS_ST_OFF, inc: EBS_INC_RST, imsk: EBS_MASK_RST, default: '0};

	ebs_state_t q_ff;
	ebs_state_t nxt_q;

	// Decoded synchronised pins
	logic pwr, cab, newm, rst_in, estop, home;
	logic [11:0] mv;
	logic [15:0] rpm;
	logic pwr_up, rst_rise, home_rise;
	assign {pwr, cab, newm, rst_in, estop, home, mv, rpm} = q_ff.s2;
	assign pwr_up = (q_ff.st == EBS_ST_OFF) && pwr;
	assign rst_rise = rst_in && !q_ff.p[2];
	assign home_rise = home && !q_ff.p[0];

	always_comb
	begin
		logic set_b;
		logic set_e;
		logic clr_b;
		logic wr_do;
		logic [EBS_EV_W-1:0] ev;
		logic [EBS_EV_W-1:0] w1c;
		set_b = 1'b0;
		set_e = 1'b0;
		clr_b = 1'b0;
		wr_do = 1'b0;
		ev = '0;
		w1c = '0;
		nxt_q = q_ff;
		nxt_q.s1 = {ctrl_pwr_on, cable_ok, motor_new, reset_in, estop_in, home_done, bkp_mv, speed_rpm};
		nxt_q.s2 = q_ff.s1;
		nxt_q.p = {pwr, rst_in, estop, home};
		// Synced pins hold reset zeros for two edges; judge nothing until refilled
		nxt_q.up = {q_ff.up[0], 1'b1};

		// Register writes, address and data in either order
		if (awvalid && q_ff.awr)
		begin
			nxt_q.aw_got = 1'b1;
			nxt_q.awa = awaddr;
		end
		if (wvalid && q_ff.wr)
		begin
			nxt_q.w_got = 1'b1;
			nxt_q.wd = wdata;
			nxt_q.ws = wstrb;
		end
		if (q_ff.bv && bready)
			nxt_q.bv = 1'b0;
		wr_do = q_ff.aw_got && q_ff.w_got && !q_ff.bv;
		if (wr_do)
		begin
			nxt_q.aw_got = 1'b0;
			nxt_q.w_got = 1'b0;
			nxt_q.bv = 1'b1;
			nxt_q.br = EBS_OKAY;
			case (q_ff.awa)
				EBS_CTRL:
					if (q_ff.ws[0])
					begin
						nxt_q.inc = q_ff.wd[EBS_CTRL_INC];
						clr_b = q_ff.wd[EBS_CTRL_CLR];
					end
				EBS_STATUS: ;
				EBS_IRQ_STAT:
					if (q_ff.ws[0])
						w1c = q_ff.wd[EBS_EV_W-1:0];
				EBS_IRQ_MASK:
					if (q_ff.ws[0])
						nxt_q.imsk = q_ff.wd[EBS_EV_W-1:0];
				default: nxt_q.br = EBS_SLVERR;
			endcase
		end
		nxt_q.awr = !nxt_q.aw_got && !nxt_q.bv;
		nxt_q.wr = !nxt_q.w_got && !nxt_q.bv;

		// Power phases: watch backup while off, judge at power-up
		nxt_q.abs = !q_ff.inc;
		case (q_ff.st)
			EBS_ST_OFF:
			begin
				nxt_q.enc = 1'b0;
				if (q_ff.abs && !pwr && q_ff.up[1])
				begin
					if (mv < EBS_MIN_MV)
						nxt_q.f_low = 1'b1;
					if (rpm > EBS_BKP_RPM_MAX)
						nxt_q.f_ovs = 1'b1;
					if (!cab)
						nxt_q.f_cab = 1'b1;
				end
				if (pwr)
				begin
					nxt_q.st = EBS_ST_ON;
					set_b = q_ff.abs && (newm || q_ff.f_low || q_ff.f_cab);
					set_e = q_ff.abs && (q_ff.f_ovs || rpm > EBS_PWRUP_RPM_MAX);
					nxt_q.f_low = 1'b0;
					nxt_q.f_ovs = 1'b0;
					nxt_q.f_cab = 1'b0;
				end
			end
			EBS_ST_ON:
				if (!pwr)
					nxt_q.st = EBS_ST_OFF;
				else
					set_e = q_ff.abs && !cab;
			default: nxt_q.st = EBS_ST_OFF;
		endcase

		// Error flags, a set wins over a clear
		clr_b = clr_b || rst_rise;
		nxt_q.bkp = (q_ff.bkp && !clr_b) || set_b;
		nxt_q.enc = nxt_q.enc || set_e;
		nxt_q.err = nxt_q.bkp || nxt_q.enc;
		nxt_q.inh = (q_ff.inh && !(home_rise && !q_ff.bkp && !q_ff.enc)) || set_b || set_e;

		// First error to occur is the one shown
		if (q_ff.disp == EBS_DSP_NONE)
		begin
			if (estop)
				nxt_q.disp = EBS_DSP_OTHER;
			else if (set_e)
				nxt_q.disp = EBS_DSP_ENC;
			else if (set_b)
				nxt_q.disp = EBS_DSP_BKP;
		end
		else if (!q_ff.bkp && !q_ff.enc && !estop)
			nxt_q.disp = EBS_DSP_NONE;

		// Low-voltage flash on this axis's own indicator
		nxt_q.low = q_ff.abs && q_ff.up[1] && (mv <= EBS_WARN_MV);
		if (!q_ff.low)
		begin
			nxt_q.led = 1'b0;
			nxt_q.cnt = '0;
		end
		else if (q_ff.cnt == CW'(BLINK_CYC - 1))
		begin
			nxt_q.led = !q_ff.led;
			nxt_q.cnt = '0;
		end
		else
			nxt_q.cnt = q_ff.cnt + CW'(1);

		// Sticky events, set wins over write-one-to-clear
		ev[EBS_EV_BKP] = set_b && !q_ff.bkp;
		ev[EBS_EV_ENC] = set_e && !q_ff.enc;
		ev[EBS_EV_LOW] = nxt_q.low && !q_ff.low;
		ev[EBS_EV_HOME] = home_rise;
		nxt_q.ist = (q_ff.ist & ~w1c) | ev;
		nxt_q.irq = |(nxt_q.ist & nxt_q.imsk);

		// Register reads
		if (q_ff.rv && rready)
			nxt_q.rv = 1'b0;
		if (arvalid && q_ff.arr)
		begin
			nxt_q.rv = 1'b1;
			nxt_q.rr = EBS_OKAY;
			nxt_q.rd = '0;
			case (araddr)
				EBS_CTRL: nxt_q.rd[EBS_CTRL_INC] = q_ff.inc;
				EBS_STATUS: nxt_q.rd[7:0] = {q_ff.disp, q_ff.err, q_ff.abs, q_ff.inh, q_ff.low, q_ff.enc, q_ff.bkp};
				EBS_IRQ_STAT: nxt_q.rd[EBS_EV_W-1:0] = q_ff.ist;
				EBS_IRQ_MASK: nxt_q.rd[EBS_EV_W-1:0] = q_ff.imsk;
				default: nxt_q.rr = EBS_SLVERR;
			endcase
		end
		nxt_q.arr = !nxt_q.rv;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			q_ff <= Q_RST;
		else
			q_ff <= nxt_q;
	end

	assign awready = q_ff.awr;
	assign wready = q_ff.wr;
	assign bvalid = q_ff.bv;
	assign bresp = q_ff.br;
	assign arready = q_ff.arr;
	assign rvalid = q_ff.rv;
	assign rdata = q_ff.rd;
	assign rresp = q_ff.rr;
	assign led_green = q_ff.led;
	assign err_out = q_ff.err;
	assign motion_inhibit = q_ff.inh;
	assign abs_active = q_ff.abs;
	assign disp_err = q_ff.disp;
	assign irq = q_ff.irq;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	inc_abs_off_a: assert property (q_ff.inc |=> !abs_active)
		else $error("absolute tracking active in incremental mode");
	led_idle_a: assert property (!q_ff.low |=> !led_green)
		else $error("indicator lit without low supply");
	warn_no_err_a: assert property (err_out == (q_ff.bkp || q_ff.enc))
		else $error("error output not tied to errors");
	bkp_new_a: assert property (pwr_up && q_ff.abs && newm |=> q_ff.bkp)
		else $error("no backup error for new motor");
	bkp_cable_a: assert property (pwr_up && q_ff.f_cab |=> q_ff.bkp && err_out)
		else $error("no backup error after cable drop");
	bkp_low_a: assert property (pwr_up && q_ff.f_low |=> q_ff.bkp)
		else $error("no backup error after low supply");
	bkp_clear_a: assert property (rst_rise && !pwr_up |=> !q_ff.bkp)
		else $error("backup error not cleared");
	enc_ovs_a: assert property (pwr_up && q_ff.f_ovs |=> q_ff.enc)
		else $error("no encoder error after overspeed");
	enc_spd_a: assert property (pwr_up && q_ff.abs && rpm > EBS_PWRUP_RPM_MAX |=> q_ff.enc)
		else $error("no encoder error for spinning motor");
	enc_cable_a: assert property (q_ff.st == EBS_ST_ON && pwr && q_ff.abs && !cab |=> q_ff.enc)
		else $error("no encoder error on cable loss");
	enc_hold_a: assert property (q_ff.enc && q_ff.st == EBS_ST_ON && pwr |=> q_ff.enc)
		else $error("encoder error cleared while powered");
	inh_err_a: assert property ((q_ff.bkp || q_ff.enc) |-> motion_inhibit)
		else $error("motion allowed with error");
	disp_keep_a: assert property (q_ff.disp != EBS_DSP_NONE && estop |=> $stable(disp_err))
		else $error("displayed error replaced");
	inh_home_a: assert property (motion_inhibit && !home_rise |=> motion_inhibit)
		else $error("inhibit released without homing");

	bkp_seen_c: cover property (pwr_up ##1 q_ff.bkp ##[1:20] !q_ff.bkp);
	enc_seen_c: cover property (q_ff.enc ##[1:50] !motion_inhibit);
	wr_rd_c: cover property (bvalid && bready ##[1:10] rvalid && rready);
endmodule
`default_nettype wire

// *** verif/ebs_enc_model.sv ***
// Encoder with backup supply as seen at the supervisor pins.
// Assumes the bench sets the wanted state right after a clock edge.
`default_nettype none
module ebs_enc_model (
	// Wanted state
	input wire logic plug,
	input wire logic fresh,
	input wire logic [11:0] mv,
	input wire logic [15:0] rpm,
	// Pins
	output logic cable_ok,
	output logic motor_new,
	output logic [11:0] bkp_mv,
	output logic [15:0] speed_rpm
);
	timeunit 1ns;
	timeprecision 1ns;
	assign cable_ok = plug;
	assign motor_new = fresh;
	assign bkp_mv = mv;
	// Unplugged cable carries no speed
	assign speed_rpm = plug ? rpm : 16'h0000;
endmodule
`default_nettype wire

// *** verif/tb_ebs_top.sv ***
// Self-checking bench of the encoder backup supervisor.
// Assumes the package, design and encoder model are compiled first.
`default_nettype none
module tb_ebs_top;
	timeunit 1ns;
	timeprecision 1ns;
	import ebs_pkg::*;
	localparam int BLK = 8;
	localparam logic [1:0] EXP_D [4] = '{EBS_DSP_BKP, EBS_DSP_ENC, EBS_DSP_BKP, EBS_DSP_NONE};
	logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0, rdata, d;
	logic [3:0] wstrb = 4'hF;
	logic awready, wready, bvalid, arready, rvalid, irq, led_green, err_out, motion_inhibit, abs_active;
	logic [1:0] bresp, rresp, disp_err, r;
	logic pwr = 0, plug = 1, fresh = 0, rst_in = 0, estop = 0, home = 0;
	logic cable_ok, motor_new;
	logic [11:0] mv = 12'hE10, bkp_mv;
	logic [15:0] rpm = '0, speed_rpm;
	int n_errors = 0, n_tests = 0, cyc = 0;
	ebs_top #(.BLINK_CYC(BLK)) u_ebs_top (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
		.wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready, .ctrl_pwr_on(pwr), .cable_ok, .motor_new, .reset_in(rst_in), .estop_in(estop),
		.home_done(home), .bkp_mv, .speed_rpm, .led_green, .err_out, .motion_inhibit, .abs_active,
		.disp_err, .irq);
	ebs_enc_model u_ebs_enc_model (.plug, .fresh, .mv, .rpm, .cable_ok, .motor_new, .bkp_mv, .speed_rpm);
	always #20 aclk = ~aclk;
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 5000)
		begin
			n_errors++;
			stop_test();
		end
	end
	task automatic stop_test;
		if (n_errors == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			n_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic aw, w;
		aw = 0;
		w = 0;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1;
		wvalid <= 1;
		bready <= 1;
		while (!(aw && w))
		begin
			@(posedge aclk);
			if (!aw && awready === 1'b1)
			begin
				aw = 1;
				awvalid <= 0;
			end
			if (!w && wready === 1'b1)
			begin
				w = 1;
				wvalid <= 0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		r = bresp;
		bready <= 0;
		@(posedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		araddr <= a;
		arvalid <= 1;
		rready <= 1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		d = rdata;
		r = rresp;
		rready <= 0;
		@(posedge aclk);
	endtask
	function automatic logic [31:0] sv(input logic b, e, l, h, input logic [1:0] p);
		return {24'h0, p, b | e, 1'b1, h, l, e, b};
	endfunction
	task automatic ckst(input logic [31:0] e);
		rd(EBS_STATUS);
		chk("rresp", {30'h0, EBS_OKAY}, {30'h0, r});
		chk("status", e, d);
	endtask
	task automatic pw(input logic v);
		pwr <= v;
		tick(5);
	endtask
	task automatic pulse(input logic h);
		{home, rst_in} <= h ? 2'b10 : 2'b01;
		tick(5);
		{home, rst_in} <= 2'b00;
		tick(5);
	endtask
	task automatic t_regs;
		rd(EBS_IRQ_MASK);
		chk("mask_rst", {28'h0, EBS_MASK_RST}, d);
		rd(EBS_CTRL);
		chk("ctrl_rst", {31'h0, EBS_INC_RST}, d);
		rd(8'h10);
		chk("unmapped", {30'h0, EBS_SLVERR}, {30'h0, r});
		rd(EBS_IRQ_STAT);
		chk("irq_stat_rst", 32'h0000_0000, d);
		wr(8'h10, 32'h0000_0001);
		chk("wr_unmapped", {30'h0, EBS_SLVERR}, {30'h0, r});
		ckst(sv(0, 0, 0, 0, EBS_DSP_NONE));
	endtask
	task automatic t_new;
		fresh <= 1;
		pw(1);
		fresh <= 0;
		chk("irq_masked", 0, {31'h0, irq});
		wr(EBS_IRQ_MASK, 32'h0000_000F);
		chk("bresp", {30'h0, EBS_OKAY}, {30'h0, r});
		tick(2);
		chk("irq", 1, {31'h0, irq});
		ckst(sv(1, 0, 0, 1, EBS_DSP_BKP));
		pulse(1);
		ckst(sv(1, 0, 0, 1, EBS_DSP_BKP));
		wr(EBS_CTRL, 32'h0000_0002);
		ckst(sv(0, 0, 0, 1, EBS_DSP_NONE));
		wr(EBS_IRQ_STAT, 32'h0000_000F);
		tick(2);
		chk("irq_clr", 0, {31'h0, irq});
		pulse(1);
		ckst(sv(0, 0, 0, 0, EBS_DSP_NONE));
		chk("irq_home", 1, {31'h0, irq});
	endtask
	task automatic t_enc;
		plug <= 0;
		tick(5);
		plug <= 1;
		ckst(sv(0, 1, 0, 1, EBS_DSP_ENC));
		pulse(0);
		wr(EBS_CTRL, 32'h0000_0002);
		chk("err_out", 1, {31'h0, err_out});
		pw(0);
		pw(1);
		ckst(sv(0, 0, 0, 1, EBS_DSP_NONE));
		pulse(1);
		for (int i = 0; i < 2; i++)
		begin
			pw(0);
			rpm <= EBS_PWRUP_RPM_MAX + 16'(i);
			pw(1);
			rpm <= '0;
			chk("err_out", 32'(i), {31'h0, err_out});
		end
		pw(0);
		pw(1);
		pulse(1);
	endtask
	task automatic t_off;
		for (int k = 0; k < 4; k++)
		begin
			pw(0);
			mv <= (k == 0) ? EBS_MIN_MV - 12'h001 : (k == 3) ? EBS_MIN_MV : 12'hE10;
			rpm <= (k == 1) ? EBS_BKP_RPM_MAX + 16'h0001 : 16'h0000;
			plug <= (k != 2);
			tick(5);
			mv <= 12'hE10;
			rpm <= '0;
			plug <= 1;
			pw(1);
			chk("disp_err", {30'h0, EXP_D[k]}, {30'h0, disp_err});
			pulse(0);
			chk("err_out", 32'(k == 1), {31'h0, err_out});
			pulse(1);
		end
	endtask
	task automatic t_low;
		int n;
		logic p;
		for (int k = 0; k < 2; k++)
		begin
			mv <= EBS_WARN_MV + 12'(k);
			tick(5);
			n = 0;
			p = led_green;
			repeat (4 * BLK)
			begin
				@(posedge aclk);
				n += (led_green !== p);
				p = led_green;
			end
			chk("led_flash", 1, 32'((k == 0) ? (n >= 3 && n <= 5) : (n == 0)));
			chk("err_out", 0, {31'h0, err_out});
			ckst(sv(0, 0, k == 0, 0, EBS_DSP_NONE));
		end
		mv <= 12'hE10;
		wr(EBS_CTRL, 32'h0000_0001);
		plug <= 0;
		mv <= 12'h7D0;
		tick(5);
		chk("abs_active", 0, {31'h0, abs_active});
		chk("err_led", 0, {30'h0, err_out, led_green});
		plug <= 1;
		mv <= 12'hE10;
		wr(EBS_CTRL, 32'h0000_0000);
		tick(5);
	endtask
	task automatic t_disp;
		estop <= 1;
		tick(5);
		plug <= 0;
		tick(5);
		chk("disp_err", {30'h0, EBS_DSP_OTHER}, {30'h0, disp_err});
		chk("inhibit", 1, {31'h0, motion_inhibit});
		plug <= 1;
		estop <= 0;
		pw(0);
		pw(1);
		pulse(1);
		ckst(sv(0, 0, 0, 0, EBS_DSP_NONE));
	endtask
	initial
	begin
		tick(12);
		aresetn <= 1;
		tick(3);
		t_regs();
		t_new();
		t_enc();
		t_off();
		t_low();
		t_disp();
		stop_test();
	end
endmodule
`default_nettype wire
